/* include/adc_fmt_pkg.sv */
// Constants for the converter result formatting and reference select block
package adc_fmt_pkg;
    localparam logic [7:0] INPUT_REF_SEL_OFFSET = 8'h7C;
    localparam logic [7:0] RESULT_LOW_OFFSET = 8'h78;
    localparam logic [7:0] RESULT_HIGH_OFFSET = 8'h79;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h80;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h81;
    localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h82;
    localparam logic [7:0] INPUT_REF_SEL_RESET = 8'h00;
    localparam int REF_SEL_MSB = 7;
    localparam int REF_SEL_LSB = 6;
    localparam int LEFT_ALIGN_BIT = 5;
    localparam int CHAN_SEL_MSB = 4;
    localparam int CHAN_SEL_LSB = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int RESULT_W = 10;
    localparam logic [9:0] SE_CODE_MIN = 10'h000;
    localparam logic [9:0] SE_CODE_MAX = 10'h3FF;
    localparam logic [9:0] DIFF_CODE_MIN = 10'h200;
    localparam logic [9:0] DIFF_CODE_MAX = 10'h1FF;
    typedef enum logic [1:0] {
        REF_EXTERNAL_PIN = 2'b00,
        REF_ANALOG_SUPPLY = 2'b01,
        REF_INTERNAL_1V1 = 2'b10,
        REF_INTERNAL_2V56 = 2'b11
    } ref_sel_t;
endpackage : adc_fmt_pkg

/* logic/adc_result_format.sv */
// Result formatting, input/reference select register and done interrupt
`timescale 1ns/1ps
// Notes on behaviour
// - Single-ended results are unsigned 10-bit codes, 0x000 ground to 0x3FF.
// - Differential results are two's complement, 0x200 up to 0x1FF.
// - Top result bit is the sign in differential results.
// - Result bytes load the finished value as the done flag sets.
// - Reference field: external pin, analog supply, 1.1V, 2.56V.
// - Reference writes during a conversion apply only at its completion.
// - Alignment bit one left-justifies, zero right-justifies the result.
// - Alignment changes reformat the result bytes at once.
// - Select register: 8-bit RW at 0x7C, reset zero, fields 7:6,5,4:0.
// - Right: low=bits 7:0, high=9:8; left: high=9:2, low top=1:0.
// - Channel/gain writes during a conversion apply only at its completion.
// - Done flag sets on completion; clears by writing one or vector taken.
module adc_result_format
    import adc_fmt_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic conv_busy,
    input wire logic conv_done,
    input wire logic [RESULT_W-1:0] conv_value,
    input wire logic conv_differential,
    input wire logic int_vector_taken,
    output logic done_flag,
    output logic [1:0] active_ref_sel,
    output logic [4:0] active_chan_sel,
    output logic irq
);
    logic [7:0] sel_reg_q;
    logic [1:0] act_ref_q;
    logic [4:0] act_chan_q;
    logic [RESULT_W-1:0] result_q;
    logic done_q;
    logic irq_en_q;
    logic irq_q;
    logic [7:0] rdata_q;
    logic [7:0] res_low_d;
    logic [7:0] res_high_d;
    logic left_align;
    logic done_d;
    logic irq_en_d;

    // Result code is kept raw; both single-ended and differential codes are
    // stored as delivered, the converter supplies its native format
    function automatic logic [15:0] align_result(input logic [9:0] v, input logic left);
        if (left) begin
            align_result = {v[9:2], v[1:0], 6'h00};
        end else begin
            align_result = {6'h00, v[9:8], v[7:0]};
        end
    endfunction : align_result

    assign left_align = sel_reg_q[LEFT_ALIGN_BIT];

    // Formatting is combinational from the live align bit, not the latched one
    always_comb begin
        {res_high_d, res_low_d} = align_result(result_q, left_align);
    end

    // Select register, readable and writable at any time
    always_ff @(posedge clk) begin
        if (reset) begin
            sel_reg_q <= INPUT_REF_SEL_RESET;
        end else if (wr_en && addr == INPUT_REF_SEL_OFFSET) begin
            sel_reg_q <= wdata;
        end
    end

    // Settings seen by the analog side; frozen while a conversion runs
    always_ff @(posedge clk) begin
        if (reset) begin
            act_ref_q <= REF_EXTERNAL_PIN;
            act_chan_q <= 5'h00;
        end else if (!conv_busy || conv_done) begin
            act_ref_q <= sel_reg_q[REF_SEL_MSB:REF_SEL_LSB];
            act_chan_q <= sel_reg_q[CHAN_SEL_MSB:CHAN_SEL_LSB];
        end
    end

    // Raw code capture; sign of differential results is bit 9 unchanged
    always_ff @(posedge clk) begin
        if (reset) begin
            result_q <= SE_CODE_MIN;
        end else if (conv_done) begin
            result_q <= conv_value;
        end
    end

    // Done flag next value; set beats either clear so no completion is lost
    always_comb begin
        done_d = done_q;
        if (conv_done) begin
            done_d = 1'b1;
        end else if (int_vector_taken) begin
            done_d = 1'b0;
        end else if (wr_en && addr == IRQ_CLEAR_OFFSET && wdata[IRQ_DONE_BIT]) begin
            done_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    always_comb begin
        irq_en_d = irq_en_q;
        if (wr_en && addr == IRQ_ENABLE_OFFSET) begin
            irq_en_d = wdata[IRQ_DONE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_en_q <= 1'b0;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    // Built from next values: a flip-flop output that still has no lag
    // behind the flag or the enable
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= done_d && irq_en_d;
        end
    end

    // Read port; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (rd_en) begin
            if (addr == INPUT_REF_SEL_OFFSET) begin
                rdata_q <= sel_reg_q;
            end else if (addr == RESULT_LOW_OFFSET) begin
                rdata_q <= res_low_d;
            end else if (addr == RESULT_HIGH_OFFSET) begin
                rdata_q <= res_high_d;
            end else if (addr == IRQ_STATUS_OFFSET) begin
                rdata_q <= {7'h00, done_q};
            end else if (addr == IRQ_ENABLE_OFFSET) begin
                rdata_q <= {7'h00, irq_en_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata = rdata_q;
    assign done_flag = done_q;
    assign active_ref_sel = act_ref_q;
    assign active_chan_sel = act_chan_q;
    assign irq = irq_q;

    a_ref_held_busy: assert property (@(posedge clk) disable iff (reset)
        conv_busy && !conv_done |=> $stable(active_ref_sel))
        else $error("reference changed during conversion");

    a_chan_held_busy: assert property (@(posedge clk) disable iff (reset)
        conv_busy && !conv_done |=> $stable(active_chan_sel))
        else $error("channel changed during conversion");

    a_ref_applied_done: assert property (@(posedge clk) disable iff (reset)
        conv_done && !(wr_en && addr == INPUT_REF_SEL_OFFSET)
        |=> active_ref_sel == $past(sel_reg_q[7:6]))
        else $error("reference not applied at completion");

    a_done_sets: assert property (@(posedge clk) disable iff (reset)
        conv_done |=> done_flag)
        else $error("done flag not set");

    a_done_clears: assert property (@(posedge clk) disable iff (reset)
        !conv_done && int_vector_taken |=> !done_flag)
        else $error("done flag not cleared by vector");

    sequence s_capture;
        conv_done ##1 (rd_en && addr == RESULT_HIGH_OFFSET && !left_align);
    endsequence
    a_right_high: assert property (@(posedge clk) disable iff (reset)
        s_capture |=> rdata == {6'h00, $past(conv_value[9:8], 2)})
        else $error("right aligned high byte wrong");

    a_left_low: assert property (@(posedge clk) disable iff (reset)
        rd_en && addr == RESULT_LOW_OFFSET && left_align |=> rdata[5:0] == 6'h00)
        else $error("left aligned low byte padding not zero");

    a_left_high: assert property (@(posedge clk) disable iff (reset)
        rd_en && addr == RESULT_HIGH_OFFSET && left_align |=> rdata == $past(result_q[9:2]))
        else $error("left aligned high byte wrong");

    a_sel_reset: assert property (@(posedge clk)
        $past(reset) |-> sel_reg_q == INPUT_REF_SEL_RESET)
        else $error("select register not reset");

    a_irq_level: assert property (@(posedge clk) disable iff (reset)
        irq == (done_flag && irq_en_q))
        else $error("interrupt level does not follow flag and enable");

    a_irq_masked: assert property (@(posedge clk) disable iff (reset)
        !irq_en_q |-> !irq)
        else $error("interrupt raised while masked");

    // Capture checks
    a_diff_sign: assert property (@(posedge clk) disable iff (reset)
        conv_done && conv_differential |=> result_q[9] == $past(conv_value[9]))
        else $error("differential sign bit not kept");

    a_capture: assert property (@(posedge clk) disable iff (reset)
        conv_done |=> result_q == $past(conv_value))
        else $error("result not captured at completion");

    a_flag_result: assert property (@(posedge clk) disable iff (reset)
        $rose(done_flag) |-> result_q == $past(conv_value))
        else $error("done flag set without fresh result");

    // Read side, built from the two byte reads
    sequence s_read_low;
        rd_en && addr == RESULT_LOW_OFFSET;
    endsequence

    sequence s_read_high;
        rd_en && addr == RESULT_HIGH_OFFSET;
    endsequence

    a_right_low: assert property (@(posedge clk) disable iff (reset)
        s_read_low ##0 !left_align |=> rdata == $past(result_q[7:0]))
        else $error("right aligned low byte wrong");

    a_right_pad: assert property (@(posedge clk) disable iff (reset)
        s_read_high ##0 !left_align |=> rdata[7:2] == 6'h00)
        else $error("right aligned high byte padding not zero");

    a_right_bits: assert property (@(posedge clk) disable iff (reset)
        s_read_high ##0 !left_align |=> rdata[1:0] == $past(result_q[9:8]))
        else $error("right aligned high bits wrong");

    a_left_bits: assert property (@(posedge clk) disable iff (reset)
        s_read_low ##0 left_align |=> rdata[7:6] == $past(result_q[1:0]))
        else $error("left aligned low bits wrong");

    a_status_read: assert property (@(posedge clk) disable iff (reset)
        rd_en && addr == IRQ_STATUS_OFFSET |=> rdata == {7'h00, $past(done_flag)})
        else $error("status read wrong");

    // Select register access
    a_sel_write: assert property (@(posedge clk) disable iff (reset)
        wr_en && addr == INPUT_REF_SEL_OFFSET |=> sel_reg_q == $past(wdata))
        else $error("select write lost");

    a_sel_read: assert property (@(posedge clk) disable iff (reset)
        rd_en && addr == INPUT_REF_SEL_OFFSET |=> rdata == $past(sel_reg_q))
        else $error("select read wrong");

    a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
        !rd_en |=> rdata == 8'h00)
        else $error("read data not zero outside a read");

    // Settings applied to the analog side
    a_ref_idle: assert property (@(posedge clk) disable iff (reset)
        !conv_busy |=> active_ref_sel == $past(sel_reg_q[REF_SEL_MSB:REF_SEL_LSB]))
        else $error("reference not tracking while idle");

    a_chan_idle: assert property (@(posedge clk) disable iff (reset)
        !conv_busy |=> active_chan_sel == $past(sel_reg_q[CHAN_SEL_MSB:CHAN_SEL_LSB]))
        else $error("channel not tracking while idle");

    a_chan_applied: assert property (@(posedge clk) disable iff (reset)
        conv_done |=> active_chan_sel == $past(sel_reg_q[CHAN_SEL_MSB:CHAN_SEL_LSB]))
        else $error("channel not applied at completion");

    // Flag life cycle
    a_done_wclear: assert property (@(posedge clk) disable iff (reset)
        !conv_done && wr_en && addr == IRQ_CLEAR_OFFSET && wdata[IRQ_DONE_BIT] |=> !done_flag)
        else $error("done flag not cleared by write");

    a_done_holds: assert property (@(posedge clk) disable iff (reset)
        done_flag && !int_vector_taken
        && !(wr_en && addr == IRQ_CLEAR_OFFSET && wdata[IRQ_DONE_BIT]) |=> done_flag)
        else $error("done flag dropped without a clear");

    // Reset values of the outputs
    a_reset_outputs: assert property (@(posedge clk)
        $past(reset) |-> rdata == 8'h00 && !done_flag && !irq)
        else $error("outputs not cleared by reset");

    a_reset_selects: assert property (@(posedge clk)
        $past(reset) |-> active_ref_sel == REF_EXTERNAL_PIN && active_chan_sel == 5'h00)
        else $error("applied selects not cleared by reset");
endmodule : adc_result_format

/* bench/adc_result_format_tb.sv */
// Self-checking bench for result formatting, select register and done interrupt
`timescale 1ns/1ps
module adc_result_format_tb;
    import adc_fmt_pkg::*;
    logic clk = 0, reset = 1, wr_en = 0, rd_en = 0, conv_busy = 0, conv_done = 0;
    logic conv_differential = 0, int_vector_taken = 0, done_flag, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [9:0] conv_value = 10'h000;
    logic [1:0] active_ref_sel;
    logic [4:0] active_chan_sel;
    int fail_count = 0, checks = 0, cycles = 0;
    adc_result_format dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .conv_busy(conv_busy),
        .conv_done(conv_done), .conv_value(conv_value), .conv_differential(conv_differential),
        .int_vector_taken(int_vector_taken), .done_flag(done_flag),
        .active_ref_sel(active_ref_sel), .active_chan_sel(active_chan_sel), .irq(irq));
    always #2.5 clk = ~clk;
    // Hang guard well beyond the roughly 71 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
        @(posedge clk) wr_en <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [7:0] a, string what, logic [7:0] exp);
        @(posedge clk) begin addr <= a; rd_en <= 1'b1; end
        @(posedge clk) rd_en <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask : rd
    task automatic convert(logic [9:0] v, logic diff, logic exp_irq);
        @(posedge clk) begin conv_value <= v; conv_differential <= diff; conv_done <= 1'b1; end
        @(posedge clk) begin conv_done <= 1'b0; conv_busy <= 1'b0; end
        #1 chk("done", 8'h01, {7'h0, done_flag});
        chk("irq", {7'h0, exp_irq}, {7'h0, irq});
        @(posedge clk) #1 chk("irq held", {7'h0, exp_irq}, {7'h0, irq});
    endtask : convert
    task automatic t_reset_and_select();
        rd(INPUT_REF_SEL_OFFSET, "sel reset", INPUT_REF_SEL_RESET);
        rd(RESULT_HIGH_OFFSET, "high reset", 8'h00);
        rd(8'h55, "unmapped", 8'h00);
        wr(INPUT_REF_SEL_OFFSET, 8'hED);
        rd(INPUT_REF_SEL_OFFSET, "sel rw", 8'hED);
        chk("ref idle", {6'h0, REF_INTERNAL_2V56}, {6'h0, active_ref_sel});
        chk("chan idle", 8'h0D, {3'h0, active_chan_sel});
        $display("test reset_and_select done");
    endtask : t_reset_and_select
    task automatic t_held_select_and_format();
        wr(IRQ_ENABLE_OFFSET, 8'h01);
        @(posedge clk) conv_busy <= 1'b1;
        wr(INPUT_REF_SEL_OFFSET, 8'h62);
        @(posedge clk) #1 chk("ref held", 8'h03, {6'h0, active_ref_sel});
        chk("chan held", 8'h0D, {3'h0, active_chan_sel});
        rd(RESULT_LOW_OFFSET, "align live", 8'h00);
        convert(10'h270, 1'b1, 1'b1);
        chk("ref applied", {6'h0, REF_ANALOG_SUPPLY}, {6'h0, active_ref_sel});
        chk("chan applied", 8'h02, {3'h0, active_chan_sel});
        rd(RESULT_HIGH_OFFSET, "left high", 8'h9C);
        rd(RESULT_LOW_OFFSET, "left low", 8'h00);
        wr(INPUT_REF_SEL_OFFSET, 8'h42);
        rd(RESULT_LOW_OFFSET, "right low", 8'h70);
        rd(RESULT_HIGH_OFFSET, "right high", 8'h02);
        rd(IRQ_STATUS_OFFSET, "status", 8'h01);
        wr(IRQ_CLEAR_OFFSET, 8'h01);
        @(posedge clk) #1 chk("cleared", 8'h00, {6'h0, irq, done_flag});
        $display("test held_select_and_format done");
    endtask : t_held_select_and_format
    task automatic t_single_ended_and_vector();
        wr(IRQ_ENABLE_OFFSET, 8'h00);
        convert(10'h3FF, 1'b0, 1'b0);
        rd(RESULT_LOW_OFFSET, "se low", 8'hFF);
        rd(RESULT_HIGH_OFFSET, "se high", 8'h03);
        @(posedge clk) int_vector_taken <= 1'b1;
        @(posedge clk) int_vector_taken <= 1'b0;
        #1 chk("vector clr", 8'h00, {7'h0, done_flag});
        @(posedge clk) conv_busy <= 1'b1;
        wr(INPUT_REF_SEL_OFFSET, 8'h20);
        rd(RESULT_LOW_OFFSET, "busy left low", 8'hC0);
        rd(RESULT_HIGH_OFFSET, "busy left high", 8'hFF);
        chk("busy ref held", 8'h01, {6'h0, active_ref_sel});
        chk("busy chan held", 8'h02, {3'h0, active_chan_sel});
        @(posedge clk) conv_busy <= 1'b0;
        $display("test single_ended_and_vector done");
    endtask : t_single_ended_and_vector
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_reset_and_select();
        t_held_select_and_format();
        t_single_ended_and_vector();
        tally_and_finish();
    end
endmodule : adc_result_format_tb
